/* File: chain_cfg_device.sv */
`timescale 1ns/1ns
// Overview of operation
// - host grounds first enable, chains outputs onward
// - finished device pulls chain enable output low
// - next device takes bits within one clock
// - host streams across device boundary without pause
// - chain enable output is dedicated by default
// - feeding output must not become user I/O
// - shared lines; common done means joint user entry
// - error pulls shared status low, halting chain
// - after error host restarts from first device
// - auto restart releases status within 40 us
// - auto restart: wait status high, resend, no pulse
// - no auto restart: reconfigure low 2 us minimum
// - separate start-up clocks order user-mode entry
// - all enables low: identical data, one pass
// - shared status and done reset whole mixed chain
// - last output may float or serve as I/O
// - data sampled on rising serial clock edge
// - bytes travel least significant bit first
// - release done only after good complete load
// - user clock: 299 cycles after done to user
module chain_cfg_device #(
    parameter int CFG_BYTES            = 16,
    parameter int INTERNAL_INIT_CYCLES = 64
) (
    input  wire logic   ref_clk,
    input  wire logic   rst_n,
    input  wire logic   clk_en,
    input  wire logic   auto_restart,
    input  wire logic   use_user_clock,
    input  wire logic   ce_out_as_user_io,
    input  wire logic   ce_out_user_value,
    output logic        user_mode,
    output logic        load_done,
    output logic        error_seen,
    chain_cfg_if.device bus
);
    if (CFG_BYTES < 1 || INTERNAL_INIT_CYCLES < 1 ||
        INTERNAL_INIT_CYCLES > (1 << chain_cfg_pkg::CNT_W)) begin : g_bad_param
        $error("chain_cfg_device: parameter out of range");
    end

    typedef struct packed {
        logic [31:0] byte_cnt;
        logic [2:0]  bit_idx;
        logic [7:0]  shift;
        logic [7:0]  chk;
        logic        done;
        logic        err;
        logic        ok;
        logic        hold_ack;
        logic        ce_out_n;
    } link_t;

    typedef struct packed {
        chain_cfg_pkg::dev_state_t     state;
        logic [chain_cfg_pkg::CNT_W-1:0] cnt;
        logic                          status_o;
        logic                          status_oe;
        logic                          lc_o;
        logic                          lc_oe;
        logic                          link_hold;
        logic                          user_io;
        logic                          user_val;
        logic                          uclk_d;
        logic                          user_mode;
        logic                          load_done;
        logic                          error_seen;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{state: chain_cfg_pkg::DEV_RESET, status_oe: 1'b1,
                                   lc_oe: 1'b1, link_hold: 1'b1, default: '0};

    link_t      lr;
    link_t      ln;
    ctrl_t      cr;
    ctrl_t      cn;
    logic [7:0] byte_now;
    logic       l_user_io;
    logic       l_user_val;
    logic       s_reconfig;
    logic       s_status;
    logic       s_lc;
    logic       s_uclk;
    logic       s_ok;
    logic       s_err;
    logic       s_ack;
    logic       uclk_rise;
    logic       init_end;

    // ---------------- link domain: runs on the serial clock ----------------
    localparam link_t LINK_RST = '{hold_ack: 1'b1, ce_out_n: 1'b1, default: '0};

    sync_2ff #(.WIDTH(2)) u_sync_link (
        .clk (bus.serial_cfg_clock),
        .d   ({cr.user_io, cr.user_val}),
        .q   ({l_user_io, l_user_val})
    );

    // the enable input comes from the previous device's flop on this same
    // clock, so it is read directly: a sync stage would drop bits at handover
    always_comb begin
        ln          = lr;
        ln.hold_ack = 1'b0;
        byte_now    = {bus.serial_cfg_data, lr.shift[7:1]};
        // user value only once loaded: a stale sync stage must not eat data
        if (lr.done && l_user_io) begin
            ln.ce_out_n = l_user_val;
        end else if (bus.chain_enable_in_n) begin
            ln.ce_out_n = 1'b1;
        end else if (!lr.done) begin
            ln.shift   = byte_now;
            ln.bit_idx = lr.bit_idx + 3'h1;
            if (lr.bit_idx == chain_cfg_pkg::LAST_BIT_IDX) begin
                ln.chk      = lr.chk ^ byte_now;
                ln.byte_cnt = lr.byte_cnt + 32'h1;
                if (lr.byte_cnt == 32'(CFG_BYTES - 1)) begin
                    // image is good when all bytes xor to zero
                    ln.done     = 1'b1;
                    ln.err      = (lr.chk ^ byte_now) != 8'h00;
                    ln.ok       = !ln.err;
                    ln.ce_out_n = ln.err;
                end
            end
        end else begin
            ln.ce_out_n = lr.err;
        end
    end

    // cleared at once by the hold; the host parks the serial clock while the
    // hold can drop, so the release never meets a clock edge
    always_ff @(posedge bus.serial_cfg_clock or posedge cr.link_hold) begin
        if (cr.link_hold) begin
            lr <= LINK_RST;
        end else begin
            lr <= ln;
        end
    end

    // ---------------- control domain: runs on ref_clk ----------------
    sync_2ff #(.WIDTH(7)) u_sync_ref (
        .clk (ref_clk),
        .d   ({bus.reconfig_n, bus.status_n, bus.load_complete, bus.user_startup_clock,
               lr.ok, lr.err, lr.hold_ack}),
        .q   ({s_reconfig, s_status, s_lc, s_uclk, s_ok, s_err, s_ack})
    );

    always_comb begin
        cn          = cr;
        cn.status_o = 1'b0;
        cn.lc_o     = 1'b0;
        cn.uclk_d   = s_uclk;
        uclk_rise   = s_uclk && !cr.uclk_d;
        init_end    = use_user_clock ?
                      (uclk_rise && chain_cfg_pkg::count_done(cr.cnt,
                                                chain_cfg_pkg::USER_INIT_CYCLES)) :
                      chain_cfg_pkg::count_done(cr.cnt, INTERNAL_INIT_CYCLES);
        if (!s_reconfig) begin
            cn           = CTRL_RST;
            cn.uclk_d    = s_uclk;
        end else begin
            case (cr.state)
                chain_cfg_pkg::DEV_RESET: begin
                    cn.status_oe = 1'b0;
                    // shared line high and link cleared before taking data
                    if (s_status && s_ack) begin
                        cn.state = chain_cfg_pkg::DEV_CONFIG;
                    end
                end
                chain_cfg_pkg::DEV_CONFIG: begin
                    if (!s_status) begin
                        cn.state = chain_cfg_pkg::DEV_RESET;
                    end else if (s_err) begin
                        cn.state      = chain_cfg_pkg::DEV_ERROR;
                        cn.status_oe  = 1'b1;
                        cn.cnt        = '0;
                        cn.error_seen = 1'b1;
                    end else if (s_ok) begin
                        cn.lc_oe     = 1'b0;
                        cn.load_done = 1'b1;
                        // all devices share done, so they move on together
                        if (s_lc) begin
                            cn.state = chain_cfg_pkg::DEV_INIT;
                            cn.cnt   = '0;
                        end
                    end
                end
                chain_cfg_pkg::DEV_ERROR: begin
                    // without auto restart only a reconfigure pulse leaves here
                    if (auto_restart) begin
                        if (chain_cfg_pkg::count_done(cr.cnt,
                                chain_cfg_pkg::RESTART_TIMEOUT_CYC)) begin
                            cn.state     = chain_cfg_pkg::DEV_RESET;
                            cn.status_oe = 1'b0;
                        end else begin
                            cn.cnt = cr.cnt + 1'b1;
                        end
                    end
                end
                chain_cfg_pkg::DEV_INIT: begin
                    if (!s_status) begin
                        cn.state = chain_cfg_pkg::DEV_RESET;
                    end else if (init_end) begin
                        cn.state     = chain_cfg_pkg::DEV_USER;
                        cn.user_mode = 1'b1;
                    end else if (!use_user_clock || uclk_rise) begin
                        cn.cnt = cr.cnt + 1'b1;
                    end
                end
                chain_cfg_pkg::DEV_USER: begin
                    cn.user_io  = ce_out_as_user_io;
                    cn.user_val = ce_out_user_value;
                end
                default: begin
                    cn.state = chain_cfg_pkg::DEV_RESET;
                end
            endcase
            if (cn.state == chain_cfg_pkg::DEV_RESET) begin
                cn.lc_oe     = 1'b1;
                cn.load_done = 1'b0;
                cn.user_mode = 1'b0;
                cn.user_io   = 1'b0;
            end
        end
        cn.link_hold = (cn.state == chain_cfg_pkg::DEV_RESET) ||
                       (cn.state == chain_cfg_pkg::DEV_ERROR);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cr <= CTRL_RST;
        end else if (clk_en) begin
            cr <= cn;
        end
    end

    assign bus.chain_enable_out_n = lr.ce_out_n;
    assign bus.status_o           = cr.status_o;
    assign bus.status_oe          = cr.status_oe;
    assign bus.load_complete_o    = cr.lc_o;
    assign bus.load_complete_oe   = cr.lc_oe;
    assign user_mode              = cr.user_mode;
    assign load_done              = cr.load_done;
    assign error_seen             = cr.error_seen;
endmodule // chain_cfg_device

/* File: chain_cfg_host.sv */
`timescale 1ns/1ns
module chain_cfg_host #(
    parameter int HALF_DIV   = 6,
    parameter int UCLK_HALF  = 5,
    parameter int BYTE_CNT_W = 32
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire logic                  start,
    input  wire logic                  auto_restart,
    input  wire logic                  user_clk_run,
    input  wire logic [BYTE_CNT_W-1:0] total_bytes,
    input  wire logic [7:0]            src_data,
    input  wire logic                  src_valid,
    output logic                       src_ready,
    output logic                       src_rewind,
    output logic                       busy,
    output logic                       cfg_done,
    output logic                       error_seen,
    chain_cfg_if.host                  bus
);
    if (HALF_DIV < 1 || HALF_DIV > 256 || UCLK_HALF < 1 || UCLK_HALF > 256 ||
        BYTE_CNT_W < 1) begin : g_bad_param
        $error("chain_cfg_host: parameter out of range");
    end

    typedef struct packed {
        chain_cfg_pkg::host_state_t      state;
        logic [chain_cfg_pkg::CNT_W-1:0] cnt;
        logic [7:0]                      div;
        logic                            sclk;
        logic                            sdata;
        logic [7:0]                      udiv;
        logic                            uclk;
        logic [7:0]                      shift;
        logic [7:0]                      next_byte;
        logic                            have;
        logic [2:0]                      bit_idx;
        logic [BYTE_CNT_W-1:0]           taken;
        logic                            reconfig_n;
        logic                            ce_first_n;
        logic                            src_ready;
        logic                            rewind;
        logic                            busy;
        logic                            cfg_done;
        logic                            error_seen;
    } host_t;

    localparam host_t HOST_RST = '{state: chain_cfg_pkg::H_IDLE, reconfig_n: 1'b1, sclk: 1'b1,
                                   default: '0};

    host_t hr;
    host_t hn;
    logic  s_status;
    logic  s_lc;
    logic  tick;
    logic  stall;
    logic  falling;
    logic  accept;
    logic  in_err;
    logic  park;

    sync_2ff #(.WIDTH(2)) u_sync (
        .clk (ref_clk),
        .d   ({bus.status_n, bus.load_complete}),
        .q   ({s_status, s_lc})
    );

    always_comb begin
        hn            = hr;
        hn.rewind     = 1'b0;
        hn.ce_first_n = 1'b0;
        tick    = hr.div == 8'(HALF_DIV - 1);
        // the clock parks high outside the frame so no stray bit is taken;
        // after the data it runs on, as a loaded device ignores it
        park    = (hr.state == chain_cfg_pkg::H_IDLE) ||
                  (hr.state == chain_cfg_pkg::H_CFG_LOW) ||
                  (hr.state == chain_cfg_pkg::H_WAIT_STATUS) ||
                  (hr.state == chain_cfg_pkg::H_ERR_WAIT) ||
                  (hr.state == chain_cfg_pkg::H_SETTLE);
        stall   = tick && hr.sclk && (park || ((hr.state == chain_cfg_pkg::H_SEND) &&
                  (hr.bit_idx == 3'h0) && !hr.have && (hr.taken != total_bytes)));
        falling = tick && hr.sclk && !stall;
        accept  = src_valid && hr.src_ready;
        in_err  = !s_status && ((hr.state == chain_cfg_pkg::H_SETTLE) ||
                  (hr.state == chain_cfg_pkg::H_SEND) ||
                  (hr.state == chain_cfg_pkg::H_WAIT_DONE));
        if (!stall) begin
            hn.div = tick ? 8'h00 : hr.div + 8'h01;
            if (tick) begin
                hn.sclk = !hr.sclk;
            end
        end
        if (!user_clk_run) begin
            hn.udiv = 8'h00;
            hn.uclk = 1'b0;
        end else if (hr.udiv == 8'(UCLK_HALF - 1)) begin
            hn.udiv = 8'h00;
            hn.uclk = !hr.uclk;
        end else begin
            hn.udiv = hr.udiv + 8'h01;
        end
        case (hr.state)
            chain_cfg_pkg::H_IDLE, chain_cfg_pkg::H_DONE: begin
                if (start) begin
                    hn.state      = chain_cfg_pkg::H_CFG_LOW;
                    hn.reconfig_n = 1'b0;
                    hn.cnt        = '0;
                    hn.busy       = 1'b1;
                    hn.cfg_done   = 1'b0;
                    hn.error_seen = 1'b0;
                    hn.rewind     = 1'b1;
                end
            end
            chain_cfg_pkg::H_CFG_LOW: begin
                if (chain_cfg_pkg::count_done(hr.cnt, chain_cfg_pkg::RECONFIG_LOW_CYC)) begin
                    hn.reconfig_n = 1'b1;
                    hn.state      = chain_cfg_pkg::H_WAIT_STATUS;
                end else begin
                    hn.cnt = hr.cnt + 1'b1;
                end
            end
            chain_cfg_pkg::H_WAIT_STATUS, chain_cfg_pkg::H_ERR_WAIT: begin
                if (s_status) begin
                    hn.state = chain_cfg_pkg::H_SETTLE;
                    hn.cnt   = '0;
                end
            end
            chain_cfg_pkg::H_SETTLE: begin
                if (chain_cfg_pkg::count_done(hr.cnt, chain_cfg_pkg::STATUS_TO_CLK_CYC)) begin
                    hn.state   = chain_cfg_pkg::H_SEND;
                    hn.bit_idx = 3'h0;
                    hn.have    = 1'b0;
                    hn.taken   = '0;
                end else begin
                    hn.cnt = hr.cnt + 1'b1;
                end
            end
            chain_cfg_pkg::H_SEND: begin
                // data changes on the falling edge, devices sample on the rising
                if (falling) begin
                    if (hr.bit_idx != 3'h0) begin
                        hn.sdata   = hr.shift[0];
                        hn.shift   = {1'b0, hr.shift[7:1]};
                        hn.bit_idx = hr.bit_idx + 3'h1;
                    end else if (hr.have) begin
                        hn.sdata   = hr.next_byte[0];
                        hn.shift   = {1'b0, hr.next_byte[7:1]};
                        hn.have    = 1'b0;
                        hn.bit_idx = 3'h1;
                    end else begin
                        hn.state = chain_cfg_pkg::H_WAIT_DONE;
                    end
                end
            end
            chain_cfg_pkg::H_WAIT_DONE: begin
                if (s_lc) begin
                    hn.state    = chain_cfg_pkg::H_DONE;
                    hn.cfg_done = 1'b1;
                    hn.busy     = 1'b0;
                end
            end
            default: begin
                hn.state = chain_cfg_pkg::H_IDLE;
            end
        endcase
        if (accept) begin
            hn.next_byte = src_data;
            hn.have      = 1'b1;
            hn.taken     = hr.taken + 1'b1;
        end
        if (in_err) begin
            // the whole chain is unconfigured now: start over from byte zero
            hn.error_seen = 1'b1;
            hn.rewind     = 1'b1;
            hn.have       = 1'b0;
            hn.taken      = '0;
            hn.bit_idx    = 3'h0;
            hn.cnt        = '0;
            hn.state      = auto_restart ? chain_cfg_pkg::H_ERR_WAIT :
                                           chain_cfg_pkg::H_CFG_LOW;
            hn.reconfig_n = auto_restart;
        end
        hn.src_ready = (hn.state == chain_cfg_pkg::H_SEND) && !hn.have &&
                       (hn.taken != total_bytes) && !accept;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hr <= HOST_RST;
        end else if (clk_en) begin
            hr <= hn;
        end
    end

    assign bus.reconfig_n         = hr.reconfig_n;
    assign bus.serial_cfg_clock   = hr.sclk;
    assign bus.serial_cfg_data    = hr.sdata;
    assign bus.user_startup_clock = hr.uclk;
    assign bus.chain_enable_in_n  = hr.ce_first_n;
    assign src_ready              = hr.src_ready;
    assign src_rewind             = hr.rewind;
    assign busy                   = hr.busy;
    assign cfg_done               = hr.cfg_done;
    assign error_seen             = hr.error_seen;
endmodule // chain_cfg_host

/* File: chain_cfg_if.sv */
`timescale 1ns/1ns
interface chain_cfg_if;
    logic reconfig_n;
    logic serial_cfg_clock;
    logic serial_cfg_data;
    logic user_startup_clock;
    logic chain_enable_in_n;
    logic chain_enable_out_n;
    logic status_o;
    logic status_oe;
    logic load_complete_o;
    logic load_complete_oe;
    logic status_n;
    logic load_complete;

    // pulled-up open-drain lines: low only while someone pulls low
    assign status_n      = !(status_oe && !status_o);
    assign load_complete = !(load_complete_oe && !load_complete_o);

    modport device (
        input  reconfig_n, serial_cfg_clock, serial_cfg_data, user_startup_clock,
        input  chain_enable_in_n, status_n, load_complete,
        output chain_enable_out_n, status_o, status_oe, load_complete_o, load_complete_oe
    );
    modport host (
        output reconfig_n, serial_cfg_clock, serial_cfg_data, user_startup_clock,
        output chain_enable_in_n,
        input  status_n, load_complete
    );
endinterface

/* File: chain_cfg_pkg.sv */
package chain_cfg_pkg;
    localparam int CLK_FREQ_MHZ        = 100;
    // longest wait: rounds down
    localparam int RESTART_TIMEOUT_US  = 40;
    localparam int RESTART_TIMEOUT_CYC = (RESTART_TIMEOUT_US * CLK_FREQ_MHZ) / 1;
    // least wait: rounds up
    localparam int RECONFIG_LOW_US     = 2;
    localparam int RECONFIG_LOW_CYC    = (RECONFIG_LOW_US * CLK_FREQ_MHZ + 0) / 1;
    localparam int STATUS_TO_CLK_US    = 1;
    localparam int STATUS_TO_CLK_CYC   = (STATUS_TO_CLK_US * CLK_FREQ_MHZ + 0) / 1;
    localparam int USER_INIT_CYCLES    = 299;
    localparam int CNT_W               = 16;
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;

    typedef enum logic [2:0] {
        DEV_RESET, DEV_CONFIG, DEV_ERROR, DEV_INIT, DEV_USER
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE, H_CFG_LOW, H_WAIT_STATUS, H_SETTLE, H_SEND, H_WAIT_DONE, H_DONE, H_ERR_WAIT
    } host_state_t;

    function automatic logic count_done(input logic [CNT_W-1:0] cnt, input int limit);
        return cnt == CNT_W'(limit - 1);
    endfunction
endpackage

/* File: chain_cfg_sva.sv */
`timescale 1ns/1ns
module chain_cfg_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reconfig_n,
    input wire logic serial_cfg_clock,
    input wire logic serial_cfg_data,
    input wire logic chain_enable_out_n,
    input wire logic status_n,
    input wire logic load_complete,
    input wire logic load_complete_oe
);
    // sync lag on both ends makes the exact release edge fuzzy, so allow a small margin
    localparam int STAT_LIM = chain_cfg_pkg::RESTART_TIMEOUT_CYC + 100;
    logic [15:0] stat_cnt_r;
    logic [15:0] low_cnt_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge ref_clk) begin
        stat_cnt_r <= (!rst_n || status_n || !reconfig_n) ? 16'h0 : stat_cnt_r + 16'h1;
        low_cnt_r  <= (!rst_n || reconfig_n) ? 16'h0 : low_cnt_r + 16'h1;
    end

    enout_done_a: assert property ($fell(chain_enable_out_n) |-> ##[0:8] !load_complete_oe)
        else $error("done not released after chain enable output fell");
    done_cause_a: assert property ($fell(load_complete_oe) |-> !chain_enable_out_n)
        else $error("done released without a complete good load");
    data_stable_a: assert property ($rose(serial_cfg_clock) |-> $stable(serial_cfg_data))
        else $error("serial data changed at rising serial clock");
    restart_time_a: assert property (stat_cnt_r < 16'(STAT_LIM))
        else $error("status held low beyond restart time-out");
    reconfig_width_a: assert property ($rose(reconfig_n) |->
        low_cnt_r >= 16'(chain_cfg_pkg::RECONFIG_LOW_CYC))
        else $error("reconfigure request low pulse too short");
    reconfig_pull_a: assert property ($fell(reconfig_n) |-> ##[1:8] !status_n)
        else $error("status not pulled low on reconfigure");
    done_held_a: assert property ($fell(load_complete) |-> (!reconfig_n || !status_n))
        else $error("shared done fell without reconfigure or error");
    status_release_a: assert property ($rose(status_n) |-> reconfig_n)
        else $error("status released while reconfigure held low");
endmodule // chain_cfg_sva

/* File: sync_2ff.sv */
`timescale 1ns/1ns
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end
endmodule // sync_2ff

/* File: testbench.sv */
`timescale 1ns/1ns
`define CHK(A, B) begin n_compared++; if ((A) !== (B)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (A), (B)); end end
module testbench;
    localparam int NB = 4;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0, start = 1'b0, auto_r = 1'b0, uclk = 1'b0, ucr = 1'b0;
    logic as_io = 1'b0, io_val = 1'b0, bad = 1'b0;
    logic src_ready, src_rewind, cfg_done, h_err, user_mode, load_done, d_err, busy;
    logic [7:0] src_data;
    logic [7:0] img [NB] = '{8'h5A, 8'hC3, 8'h17, 8'h8E};
    logic [8*NB-1:0] shreg;
    int idx = 0, rew_n = 0, rew_base = 0, fail_count = 0, n_compared = 0;

    always #5 ref_clk = ~ref_clk;

    chain_cfg_if bus ();
    chain_cfg_host i_chain_cfg_host (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .start(start), .auto_restart(auto_r), .user_clk_run(ucr), .total_bytes(32'h4),
        .src_data(src_data), .src_valid(1'b1), .src_ready(src_ready), .src_rewind(src_rewind),
        .busy(busy), .cfg_done(cfg_done), .error_seen(h_err), .bus(bus.host));
    chain_cfg_device #(.CFG_BYTES(NB), .INTERNAL_INIT_CYCLES(8)) i_chain_cfg_device (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .auto_restart(auto_r),
        .use_user_clock(uclk), .ce_out_as_user_io(as_io), .ce_out_user_value(io_val),
        .user_mode(user_mode), .load_done(load_done), .error_seen(d_err), .bus(bus.device));
    chain_cfg_sva i_chain_cfg_sva (.ref_clk(ref_clk), .rst_n(rst_n),
        .reconfig_n(bus.reconfig_n), .serial_cfg_clock(bus.serial_cfg_clock),
        .serial_cfg_data(bus.serial_cfg_data), .chain_enable_out_n(bus.chain_enable_out_n),
        .status_n(bus.status_n), .load_complete(bus.load_complete),
        .load_complete_oe(bus.load_complete_oe));

    // only the first pass after a start carries a broken checksum, so the retry must succeed
    assign src_data = img[idx] ^ ((bad && rew_n == rew_base + 1 && idx == NB - 1) ? 8'hFF : 8'h00);
    always @(posedge ref_clk) begin
        if (src_rewind) begin
            idx <= 0;
            rew_n <= rew_n + 1;
        end else if (src_ready) begin
            idx <= (idx + 1) % NB;
        end
    end

    // wire-level capture: last image bits shifted in on rising serial clock, first bit ends at 0
    always @(posedge bus.serial_cfg_clock) begin
        if (!bus.load_complete && bus.status_n) shreg <= {bus.serial_cfg_data, shreg[8*NB-1:1]};
    end

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic run(input logic b, input logic a, input logic u, input int lo, input int hi);
        int n;
        @(posedge ref_clk);
        rew_base <= rew_n;
        bad <= b;
        auto_r <= a;
        uclk <= u;
        ucr <= 1'b0;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK(busy, 1'b1)
        for (n = 0; n < 20000 && cfg_done !== 1'b1; n++) @(posedge ref_clk);
        `CHK(cfg_done, 1'b1)
        `CHK(busy, 1'b0)
        `CHK(h_err, b)
        `CHK(d_err, b && a)
        `CHK(load_done, 1'b1)
        `CHK(bus.load_complete, 1'b1)
        `CHK(bus.chain_enable_out_n, 1'b0)
        `CHK(shreg, {img[3], img[2], img[1], img[0]})
        if (u) begin
            repeat (500) @(posedge ref_clk);
            `CHK(user_mode, 1'b0)
            ucr <= 1'b1;
        end
        for (n = 0; n < 5000 && user_mode !== 1'b1; n++) @(posedge ref_clk);
        `CHK(user_mode, 1'b1)
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask

    initial begin
        #400000;
        fail_count++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (60) @(posedge ref_clk);
        run(1'b0, 1'b0, 1'b0, 2, 16);
        run(1'b1, 1'b1, 1'b0, 2, 16);
        run(1'b1, 1'b0, 1'b0, 2, 16);
        run(1'b0, 1'b0, 1'b1, 2960, 3010);
        as_io <= 1'b1;
        io_val <= 1'b1;
        repeat (40) @(posedge ref_clk);
        `CHK(bus.chain_enable_out_n, 1'b1)
        as_io <= 1'b0;
        repeat (40) @(posedge ref_clk);
        `CHK(bus.chain_enable_out_n, 1'b0)
        close_out();
    end
endmodule // testbench
